// *** logic/eag_map.vh ***
`ifndef EAG_MAP_VH
`define EAG_MAP_VH

// ****************************************************************
// addressing modes (4-bit code)
// ****************************************************************
`define EAG_MODE_ABS_OFF      4'h0
`define EAG_MODE_ABS_DISP     4'h1
`define EAG_MODE_REG          4'h2
`define EAG_MODE_REG_OFF      4'h3
`define EAG_MODE_REG_DISP     4'h4
`define EAG_MODE_REG_IDX      4'h5
`define EAG_MODE_REG_IDX_DISP 4'h6
`define EAG_MODE_IDX_DISP     4'h7
`define EAG_MODE_IP_DISP      4'h8

// ****************************************************************
// instruction formats
// ****************************************************************
`define EAG_FMT_SHORT         1'b0
`define EAG_FMT_LONG          1'b1

// ****************************************************************
// scale codes: factor is 1 << code, codes above 4 are illegal
// ****************************************************************
`define EAG_SCALE_MAX         3'h4

// ****************************************************************
// load data kinds
// ****************************************************************
`define EAG_KIND_BYTE_U       3'h0
`define EAG_KIND_BYTE_S       3'h1
`define EAG_KIND_HALF_U       3'h2
`define EAG_KIND_HALF_S       3'h3
`define EAG_KIND_WORD         3'h4

// ****************************************************************
// constants and reset values
// ****************************************************************
`define EAG_IP_BIAS           32'h00000008
`define EAG_OFFSET_W          12
`define EAG_ADDR_RST          32'h00000000

`endif

// *** logic/eag_load_format.v ***
`timescale 1ns/1ps
`include "eag_map.vh"

// ****************************************************************
// load data formatter: byte lane order, width and sign handling
// ****************************************************************
module eag_load_format
(
    input  wire [31:0] raw_word,
    input  wire [1:0]  byte_sel,
    input  wire [2:0]  kind,
    input  wire        big_endian,
    output reg  [31:0] data_out
);

    // raw_word holds the bytes in memory order: lowest address at [7:0]
    reg [7:0]  b0;
    reg [7:0]  b1;
    reg [15:0] half;

    always @*
    begin
        b0 = 8'h00;
        b1 = 8'h00;
        half = 16'h0000;
        data_out = 32'h00000000;
        case (byte_sel)
            2'h0: b0 = raw_word[7:0];
            2'h1: b0 = raw_word[15:8];
            2'h2: b0 = raw_word[23:16];
            default: b0 = raw_word[31:24];
        endcase
        b1 = byte_sel[1] ? raw_word[31:24] : raw_word[15:8];
        // a halfword takes its low-address byte from the even lane only
        if (kind == `EAG_KIND_HALF_U || kind == `EAG_KIND_HALF_S)
            b0 = byte_sel[1] ? raw_word[23:16] : raw_word[7:0];
        if (big_endian)
            half = {b0, b1};
        else
            half = {b1, b0};
        case (kind)
            `EAG_KIND_BYTE_U: data_out = {24'h000000, b0};
            `EAG_KIND_BYTE_S: data_out = {{24{b0[7]}}, b0};
            `EAG_KIND_HALF_U: data_out = {16'h0000, half};
            `EAG_KIND_HALF_S: data_out = {{16{half[15]}}, half};
            default:
                if (big_endian)
                    data_out = {raw_word[7:0], raw_word[15:8],
                                raw_word[23:16], raw_word[31:24]};
                else
                    data_out = raw_word;
        endcase
    end

endmodule

// *** logic/eag_core.v ***
`timescale 1ns/1ps
`include "eag_map.vh"

module eag_core
#(
    parameter REG_IDX_W = 5
)
(
    input  wire                 core_clk,
    input  wire                 sys_rst,
    // request from the decoder
    input  wire                 req_valid,
    input  wire [3:0]           mode,
    input  wire                 fmt,
    input  wire [11:0]          short_offset,
    input  wire [31:0]          displacement,
    input  wire [2:0]           scale,
    input  wire [31:0]          base_value,
    input  wire [31:0]          index_value,
    input  wire [31:0]          next_ip,
    input  wire                 is_store,
    input  wire [2:0]           word_count,
    input  wire [REG_IDX_W-1:0] first_reg,
    input  wire [2:0]           load_kind,
    input  wire                 big_endian,
    output wire                 req_ready,
    output reg                  mode_error,
    // bus unit side
    output reg                  bus_valid,
    output reg  [31:0]          bus_addr,
    output reg                  bus_write,
    input  wire                 bus_ready,
    input  wire [31:0]          bus_rdata,
    // register file side
    output reg  [REG_IDX_W-1:0] reg_index,
    output reg                  rf_wr_en,
    output reg  [31:0]          rf_wr_data,
    output reg                  rf_rd_en,
    output reg                  done
);

    // ****************************************************************
    // state machine
    // ****************************************************************
    localparam ST_IDLE = 1'b0;
    localparam ST_XFER = 1'b1;

    reg                 state_reg;
    reg                 state_next;
    reg [2:0]           left_reg;
    reg [2:0]           left_next;
    reg [2:0]           kind_reg;
    reg                 endian_reg;
    wire [REG_IDX_W-1:0] reg_one = {{(REG_IDX_W-1){1'b0}}, 1'b1};

    wire [31:0] off_ext = {20'h00000, short_offset};
    wire [31:0] disp_ext = displacement;
    wire [31:0] idx_scaled = index_value << scale;
    wire        scale_ok = (scale <= `EAG_SCALE_MAX);
    wire        uses_idx = (mode == `EAG_MODE_REG_IDX) ||
                           (mode == `EAG_MODE_REG_IDX_DISP) ||
                           (mode == `EAG_MODE_IDX_DISP);

    reg  [31:0] ea;
    reg         ea_bad;
    wire [31:0] fmt_data;

    // ****************************************************************
    // address computation; sums are 32 bits so carries simply drop
    // ****************************************************************
    always @*
    begin
        ea = 32'h00000000;
        ea_bad = 1'b0;
        case (mode)
            `EAG_MODE_ABS_OFF:      ea = off_ext;
            `EAG_MODE_ABS_DISP:     ea = disp_ext;
            `EAG_MODE_REG:          ea = base_value;
            `EAG_MODE_REG_OFF:      ea = base_value + off_ext;
            `EAG_MODE_REG_DISP:     ea = base_value + disp_ext;
            `EAG_MODE_REG_IDX:      ea = base_value + idx_scaled;
            `EAG_MODE_REG_IDX_DISP:
            begin
                ea = base_value + idx_scaled + disp_ext;
                ea_bad = (fmt != `EAG_FMT_LONG);
            end
            `EAG_MODE_IDX_DISP:     ea = idx_scaled + disp_ext;
            `EAG_MODE_IP_DISP:
                ea = next_ip + disp_ext + `EAG_IP_BIAS;
            default:                ea_bad = 1'b1;
        endcase
        // offset modes come from the short format, displacement from long
        if ((mode == `EAG_MODE_ABS_OFF || mode == `EAG_MODE_REG_OFF) &&
            fmt != `EAG_FMT_SHORT)
            ea_bad = 1'b1;
        if ((mode == `EAG_MODE_ABS_DISP || mode == `EAG_MODE_REG_DISP ||
             mode == `EAG_MODE_IDX_DISP || mode == `EAG_MODE_IP_DISP) &&
            fmt != `EAG_FMT_LONG)
            ea_bad = 1'b1;
        if (uses_idx && !scale_ok)
            ea_bad = 1'b1;
        if (word_count == 3'h0 || word_count > 3'h4)
            ea_bad = 1'b1;
    end

    // only a new request is taken in idle; any move in progress, single or multi-word, blocks it
    assign req_ready = (state_reg == ST_IDLE);

    eag_load_format u_fmt
    (
        .raw_word   (bus_rdata),
        .byte_sel   (bus_addr[1:0]),
        .kind       (kind_reg),
        .big_endian (endian_reg),
        .data_out   (fmt_data)
    );

    always @*
    begin
        state_next = state_reg;
        left_next = left_reg;
        case (state_reg)
            ST_IDLE:
                if (req_valid && !ea_bad)
                begin
                    state_next = ST_XFER;
                    left_next = word_count;
                end
            ST_XFER:
                if (bus_ready)
                begin
                    left_next = left_reg - 3'h1;
                    if (left_reg == 3'h1)
                        state_next = ST_IDLE;
                end
            default:
                state_next = ST_IDLE;
        endcase
    end

    // ****************************************************************
    // transfer sequencing
    // ****************************************************************
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_IDLE;
            left_reg <= 3'h0;
            kind_reg <= `EAG_KIND_WORD;
            endian_reg <= 1'b0;
            mode_error <= 1'b0;
            bus_valid <= 1'b0;
            bus_addr <= `EAG_ADDR_RST;
            bus_write <= 1'b0;
            reg_index <= {REG_IDX_W{1'b0}};
            rf_wr_en <= 1'b0;
            rf_wr_data <= 32'h00000000;
            rf_rd_en <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            left_reg <= left_next;
            mode_error <= 1'b0;
            rf_wr_en <= 1'b0;
            rf_rd_en <= 1'b0;
            done <= 1'b0;
            // a load steps its register only after the write went out,
            // so data and index stay paired on the register file port
            if (rf_wr_en && left_reg != 3'h0)
                reg_index <= reg_index + reg_one;
            case (state_reg)
                ST_IDLE:
                    if (req_valid)
                    begin
                        mode_error <= ea_bad;
                        if (!ea_bad)
                        begin
                            bus_valid <= 1'b1;
                            bus_addr <= ea;
                            bus_write <= is_store;
                            reg_index <= first_reg;
                            rf_rd_en <= is_store;
                            // multi-word moves carry no width or sign conversion
                            kind_reg <= (word_count == 3'h1) ?
                                        load_kind : `EAG_KIND_WORD;
                            endian_reg <= big_endian;
                        end
                    end
                ST_XFER:
                    if (bus_ready)
                    begin
                        rf_wr_en <= !bus_write;
                        rf_wr_data <= fmt_data;
                        if (left_reg == 3'h1)
                        begin
                            bus_valid <= 1'b0;
                            done <= 1'b1;
                        end
                        else
                        begin
                            // next word, next register
                            bus_addr <= bus_addr + 32'h00000004;
                            // a store asks for its next source register now
                            if (bus_write)
                                reg_index <= reg_index + reg_one;
                            rf_rd_en <= bus_write;
                        end
                    end
                default:
                    bus_valid <= 1'b0;
            endcase
        end
    end

endmodule

// *** sim/eag_core_properties.sv ***
`timescale 1ns/1ps
// ****************************************
// address relations at the core ports
// ****************************************
module eag_core_properties
(
    input wire        core_clk,
    input wire        sys_rst,
    input wire        req_valid,
    input wire        req_ready,
    input wire        fmt,
    input wire        bus_valid,
    input wire        bus_ready,
    input wire [3:0]  mode,
    input wire [2:0]  scale,
    input wire [2:0]  word_count,
    input wire [11:0] short_offset,
    input wire [31:0] displacement,
    input wire [31:0] base_value,
    input wire [31:0] index_value,
    input wire [31:0] next_ip,
    input wire [31:0] bus_addr
);
    // take keeps legal counts and scales up to 4; the core refuses big scales in index modes only
    wire take = req_valid && req_ready && word_count != 3'h0
        && word_count <= 3'h4 && scale <= 3'h4;
    wire [31:0] sidx = index_value << scale;
    wire [31:0] sum6 = base_value + sidx + displacement;
    wire [31:0] sum7 = sidx + displacement;
    wire [31:0] sum8 = next_ip + displacement + 32'h8;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_abs_off: assert property (take && mode == 4'h0 && !fmt
        |=> bus_addr == {20'h0, $past(short_offset)}) else $error("abs off");
    a_abs_disp: assert property (take && mode == 4'h1 && fmt
        |=> bus_addr == $past(displacement)) else $error("abs disp");
    a_reg_base: assert property (take && mode == 4'h2
        |=> bus_addr == $past(base_value)) else $error("reg base");
    a_full_sum: assert property (take && mode == 4'h6 && fmt
        |=> bus_addr == $past(sum6)) else $error("full sum");
    a_idx_disp: assert property (take && mode == 4'h7 && fmt
        |=> bus_addr == $past(sum7)) else $error("index disp");
    a_ip_rel: assert property (take && mode == 4'h8 && fmt
        |=> bus_addr == $past(sum8)) else $error("pointer rel");
    a_addr_hold: assert property (bus_valid && !bus_ready
        |=> bus_valid && $stable(bus_addr)) else $error("addr moved");
    a_bad_scale: assert property (req_valid && req_ready
        && scale > 3'h4 && mode == 4'h5 |=> !bus_valid) else $error("scale");
    cover property (take && mode == 4'h6);
    cover property (bus_valid && !bus_ready);
    cover property (req_valid && req_ready && scale > 3'h4);
endmodule
bind eag_core eag_core_properties u_props (.core_clk, .sys_rst,
    .req_valid, .req_ready, .fmt, .bus_valid, .bus_ready, .mode, .scale,
    .word_count, .short_offset, .displacement, .base_value, .index_value,
    .next_ip, .bus_addr);

// *** sim/eag_bus_model.sv ***
`timescale 1ns/1ps
// ****************************************
// bus unit: memory words after a set wait
// ****************************************
module eag_bus_model
(
    input  wire        core_clk,
    input  wire        bus_valid,
    input  wire [31:0] bus_addr,
    input  wire [1:0]  wait_cycles,
    output reg         bus_ready = 1'b0,
    output reg  [31:0] bus_rdata = 32'h0
);
    reg  [1:0]  wait_reg = 2'h0;
    wire [5:0]  wa = bus_addr[7:2];
    // byte at address a holds a[7:0]^5A, lowest address on lane 0
    wire [31:0] word = {wa, 2'h3, wa, 2'h2, wa, 2'h1, wa, 2'h0}
        ^ 32'h5A5A5A5A;
    always @(posedge core_clk)
    begin
        if (bus_valid && !bus_ready && wait_reg == wait_cycles)
        begin
            bus_ready <= 1'b1;
            bus_rdata <= word;
        end
        else
        begin
            // data toggles outside a word so a late read cannot match
            bus_ready <= 1'b0;
            bus_rdata <= ~bus_rdata;
        end
        wait_reg <= (bus_valid && !bus_ready && wait_reg != wait_cycles)
            ? wait_reg + 2'h1 : 2'h0;
    end
endmodule

// *** sim/eag_core_test.sv ***
`timescale 1ns/1ps
// ****************************************
// directed bench with a modelled bus unit
// ****************************************
module eag_core_test;
    reg         core_clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0;
    reg         fmt = 1'b0, is_store = 1'b0, big_endian = 1'b0;
    reg  [3:0]  mode = 4'h0;
    reg  [2:0]  scale = 3'h0, word_count = 3'h1, load_kind = 3'h4;
    reg  [11:0] short_offset = 12'h0;
    reg  [31:0] displacement = 32'h0, base_value = 32'h0;
    reg  [31:0] index_value = 32'h0, next_ip = 32'h0;
    reg  [4:0]  first_reg = 5'h0;
    reg  [1:0]  wait_cycles = 2'h0;
    wire        req_ready, mode_error, bus_valid, bus_write, bus_ready;
    wire        rf_wr_en, rf_rd_en, done;
    wire [31:0] bus_addr, bus_rdata, rf_wr_data;
    wire [4:0]  reg_index;
    integer     miscompares = 0;
    integer     tests_run = 0;
    eag_core u_dut (.core_clk, .sys_rst, .req_valid, .mode, .fmt,
        .short_offset, .displacement, .scale, .base_value, .index_value,
        .next_ip, .is_store, .word_count, .first_reg, .load_kind,
        .big_endian, .req_ready, .mode_error, .bus_valid, .bus_addr,
        .bus_write, .bus_ready, .bus_rdata, .reg_index, .rf_wr_en,
        .rf_wr_data, .rf_rd_en, .done);
    eag_bus_model u_bus (.core_clk, .bus_valid, .bus_addr, .wait_cycles,
        .bus_ready, .bus_rdata);
    initial forever #2 core_clk = ~core_clk;
    task close_out;
        if (miscompares == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task check(input [63:0] what, input [31:0] seen, input [31:0] want);
        tests_run = tests_run + 1;
        if (seen !== want)
        begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED %0s expected %h seen %h", what, want, seen);
        end
    endtask
    function [31:0] exp_data(input [31:0] a, input [2:0] k, input e);
        reg [7:0]  b0, b1, b2, b3;
        reg [15:0] h;
        begin
            b0 = a[7:0] ^ 8'h5A;
            b1 = (a[7:0] + 8'h1) ^ 8'h5A;
            b2 = (a[7:0] + 8'h2) ^ 8'h5A;
            b3 = (a[7:0] + 8'h3) ^ 8'h5A;
            h = e ? {b0, b1} : {b1, b0};
            case (k)
                3'h0: exp_data = {24'h0, b0};
                3'h1: exp_data = {{24{b0[7]}}, b0};
                3'h2: exp_data = {16'h0, h};
                3'h3: exp_data = {{16{h[15]}}, h};
                default: exp_data = e ? {b0, b1, b2, b3} : {b3, b2, b1, b0};
            endcase
        end
    endfunction
    task offer(input [3:0] m, input f, input [11:0] o, input [31:0] d,
        input [2:0] s, input [31:0] b, input [31:0] x, input [31:0] ip,
        input [2:0] n, input [2:0] k, input e, input st, input [4:0] r);
        {mode, fmt, short_offset, displacement, scale} = {m, f, o, d, s};
        {base_value, index_value, next_ip} = {b, x, ip};
        {word_count, load_kind, big_endian, is_store, first_reg}
            = {n, k, e, st, r};
        req_valid = 1'b1;
        @(posedge core_clk);
        #1;
        req_valid = 1'b0;
    endtask
    task collect(input [31:0] ea);
        integer i, w, r;
        begin
            w = 0;
            r = 0;
            for (i = 0; i < 80; i = i + 1)
            begin
                if (bus_valid === 1'b1 && bus_ready === 1'b1)
                begin
                    check("address", bus_addr, ea + 4 * w);
                    check("write", {31'h0, bus_write}, {31'h0, is_store});
                    check("ready", {31'h0, req_ready}, 32'h0);
                    w = w + 1;
                end
                if (rf_wr_en === 1'b1 || rf_rd_en === 1'b1)
                begin
                    check("register", {27'h0, reg_index},
                        {27'h0, first_reg + r[4:0]});
                    if (!is_store)
                        check("data", rf_wr_data, word_count > 3'h1 ?
                            exp_data(ea + 4 * r, 3'h4, big_endian) :
                            exp_data(ea, load_kind, big_endian));
                    r = r + 1;
                end
                if (done === 1'b1)
                    break;
                @(posedge core_clk);
                #1;
            end
            check("done", {31'h0, done}, 32'h1);
            check("words", w + r, 2 * word_count);
            if (done !== 1'b1)
                close_out;
        end
    endtask
    task s_refuse(input [3:0] m, input f, input [2:0] s);
        integer i, seen;
        begin
            offer(m, f, 12'h0, 32'h40, s, 32'h100, 32'h1, 32'h0, 3'h1,
                3'h4, 1'b0, 1'b0, 5'h0);
            seen = 0;
            for (i = 0; i < 4; i = i + 1)
            begin
                seen = seen + (mode_error === 1'b1);
                check("busidle", {31'h0, bus_valid}, 32'h0);
                @(posedge core_clk);
                #1;
            end
            check("refused", seen, 1);
        end
    endtask
    task s_scales;
        integer s;
        for (s = 0; s < 5; s = s + 1)
        begin
            offer(4'h5, 1'b0, 12'h0, 32'h0, s[2:0], 32'h2000, 32'h4,
                32'h0, 3'h1, 3'h4, 1'b0, 1'b0, 5'h2);
            collect(32'h2000 + (32'h4 << s));
        end
    endtask
    initial
    begin
        repeat (8) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        offer(4'h0, 1'b0, 12'hFFF, 32'h0, 3'h0, 32'h0, 32'h0, 32'h0,
            3'h1, 3'h0, 1'b0, 1'b0, 5'h1);
        collect(32'h00000FFF);
        offer(4'h1, 1'b1, 12'h0, 32'hFFFFFFF0, 3'h0, 32'h0, 32'h0, 32'h0,
            3'h1, 3'h4, 1'b0, 1'b0, 5'h1);
        collect(32'hFFFFFFF0);
        wait_cycles = 2'h3;
        offer(4'h2, 1'b0, 12'h0, 32'h0, 3'h0, 32'h1000, 32'h0, 32'h0,
            3'h1, 3'h4, 1'b1, 1'b0, 5'h3);
        collect(32'h00001000);
        offer(4'h3, 1'b0, 12'h092, 32'h0, 3'h0, 32'hFFFFFFF0, 32'h0,
            32'h0, 3'h1, 3'h3, 1'b0, 1'b0, 5'h3);
        collect(32'h00000082);
        offer(4'h4, 1'b1, 12'h0, 32'hFFFFFFC0, 3'h0, 32'h100, 32'h0,
            32'h0, 3'h4, 3'h4, 1'b1, 1'b0, 5'h8);
        collect(32'h000000C0);
        wait_cycles = 2'h0;
        s_scales;
        offer(4'h6, 1'b1, 12'h0, 32'h30, 3'h3, 32'h3000, 32'h2, 32'h0,
            3'h2, 3'h4, 1'b0, 1'b1, 5'h6);
        collect(32'h00003040);
        offer(4'h7, 1'b1, 12'h0, 32'h80, 3'h4, 32'hFFFFFFFF, 32'h10,
            32'h0, 3'h1, 3'h1, 1'b1, 1'b0, 5'h9);
        collect(32'h00000180);
        offer(4'h8, 1'b1, 12'h0, 32'h10, 3'h0, 32'h5000, 32'h0,
            32'h4000, 3'h1, 3'h2, 1'b1, 1'b0, 5'hA);
        collect(32'h00004018);
        s_refuse(4'h6, 1'b0, 3'h0);
        s_refuse(4'h5, 1'b0, 3'h5);
        s_refuse(4'h9, 1'b1, 3'h0);
        s_refuse(4'h3, 1'b1, 3'h0);
        close_out;
    end
endmodule
